/* File: core/scr_regbank.sv */
/*
 Peripheral register bank with the common conventions: a set/clear pair,
 reserved bits, a guarded mode field, a read-only state field, software
 reset and a debug control register that survives it.
 Assumes an 8-bit synchronous register port from the CPU on CLK_SYS, with
 one-cycle write and read strobes, and that HW_EVENT and RUN_DONE come from
 logic on the same clock, so they are used without synchronisers.
*/
// Notes on behaviour
// - Clear-register one clears shared bit
// - Set-register one sets shared bit
// - Both pair addresses read same value
// - Simultaneous writes: clear wins
// - Reserved bits always read zero
// - Read-only fields show only defined encodings
// - Software reset equals power-on, debug kept
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"

module scr_regbank (
	input  wire logic                  CLK_SYS,
	input  wire logic                  ARST_N,
	input  wire logic                  WR_EN,     // One-cycle write strobe
	input  wire logic                  RD_EN,     // One-cycle read strobe
	input  wire logic                  WR_CLR_EN, // Extra strobe: clear pair alongside
	input  wire logic [`SCR_AW-1:0]    ADDR,
	input  wire logic [`SCR_DW-1:0]    WDATA,
	input  wire logic [`SCR_DW-1:0]    CLR_WDATA, // Data for the extra clear strobe
	input  wire logic [`SCR_DW-1:0]    HW_EVENT,  // Hardware flag sources
	input  wire logic                  RUN_DONE,  // Same-clock run completion
	output logic      [`SCR_DW-1:0]    RDATA,
	output logic                       RVALID,
	output logic      [`SCR_DW-1:0]    FLAGS,
	output logic      [1:0]            MODE,
	output logic                       DBG_RUN
);
	logic [7:0] flags;        // Shared set/clear value
	logic [7:0] ctrl;         // Control register
	logic [7:0] next_ctrl;
	logic [1:0] mode;         // Mode field
	logic [1:0] next_mode;
	logic [7:0] dbg;          // Debug control, kept over software reset
	logic [7:0] next_dbg;
	scr_pkg::scr_state_e state;
	scr_pkg::scr_state_e next_state;
	logic [7:0] next_rdata;   // Read word for the output register
	logic       sw_rst;       // Software reset request
	logic       set_we;       // Write strobe, set address
	logic       clr_we;       // Write strobe, clear address or extra port
	logic [7:0] clr_wdata;    // Bits to clear in the pair
	// Next values of the output registers
	logic       next_rvalid;
	logic [7:0] next_flags;
	logic [1:0] next_mode_out;
	logic       next_dbg_run;

	// Pair strobes; a clear may arrive together with a set through the extra port
	// The single address bus could not otherwise reach both pair registers at once
	assign set_we = WR_EN && (ADDR == `SCR_OFS_FLAGS_SET);
	assign clr_we = (WR_EN && (ADDR == `SCR_OFS_FLAGS_CLR)) || WR_CLR_EN;
	// Bits set and cleared together: clear wins through the ordering in the leaf
	assign sw_rst = WR_EN && (ADDR == `SCR_OFS_CTRL) && WDATA[`SCR_CTRL_SWRST];

	// Shared flag value with its set/clear addresses
	// Hardware events are ORed in inside the leaf and beat a software clear
	scr_setclr_bits #(
		.MASK  (`SCR_MASK_FLAGS),
		.RST_V (`SCR_RST_FLAGS)
	) u_flags (
		.clk    (CLK_SYS),
		.arst_n (ARST_N),
		.sw_rst (sw_rst),
		.set_we (set_we),
		.clr_we (clr_we),
		.wdata     (WDATA),
		.clr_wdata (clr_wdata),
		.hw_set (HW_EVENT),
		.value  (flags)
	);

	// Clear data: the extra strobe brings its own word, a plain clear-address
	// write brings WDATA; set bits outside the clear word still take effect
	always_comb begin
		clr_wdata = 8'h00;
		if (WR_CLR_EN) begin
			clr_wdata = CLR_WDATA;
		end
		if (WR_EN && (ADDR == `SCR_OFS_FLAGS_CLR)) begin
			clr_wdata = clr_wdata | WDATA;
		end
	end

	// Control, mode and debug next values
	always_comb begin
		next_ctrl = ctrl;
		next_mode = mode;
		next_dbg  = dbg;
		if (WR_EN) begin
			case (ADDR)
				`SCR_OFS_CTRL: begin
					next_ctrl = WDATA & `SCR_MASK_CTRL;
				end
				`SCR_OFS_MODE: begin
					// A reserved encoding is dropped, the field keeps its value
					// Software must not send it; this only keeps the field defined
					if (WDATA[1:0] != 2'h3) begin
						next_mode = WDATA[1:0];
					end
				end
				`SCR_OFS_DBGCTRL: begin
					next_dbg = WDATA & `SCR_MASK_DBG;
				end
				default: begin
					// Writes to other offsets leave these registers alone
					next_ctrl = ctrl;
				end
			endcase
		end
		// Software reset restores everything but debug control
		if (sw_rst) begin
			next_ctrl = `SCR_RST_CTRL;
			next_mode = `SCR_RST_MODE;
		end
	end

	// Read-only state sequence driven by the mode field
	// DONE holds until mode goes off; a new one-shot needs mode off first
	always_comb begin
		next_state = state;
		case (state)
			scr_pkg::SCR_ST_IDLE: begin
				if (mode != scr_pkg::SCR_MODE_OFF) begin
					next_state = scr_pkg::SCR_ST_RUN;
				end
			end
			scr_pkg::SCR_ST_RUN: begin
				if (mode == scr_pkg::SCR_MODE_OFF) begin
					next_state = scr_pkg::SCR_ST_IDLE;
				end else if (RUN_DONE && mode == scr_pkg::SCR_MODE_ONE) begin
					next_state = scr_pkg::SCR_ST_DONE;
				end
			end
			scr_pkg::SCR_ST_DONE: begin
				if (mode == scr_pkg::SCR_MODE_OFF) begin
					next_state = scr_pkg::SCR_ST_IDLE;
				end
			end
			default: begin
				// Unused code 2'h2 is never shown to software
				next_state = scr_pkg::SCR_ST_IDLE;
			end
		endcase
		// Software reset wins over any transition in the same cycle
		if (sw_rst) begin
			next_state = scr_pkg::SCR_ST_IDLE;
		end
	end

	// Read mux; both pair addresses return the same shared value
	// Reserved positions are masked here as well as at the store
	always_comb begin
		next_rdata = 8'h00;
		case (ADDR)
			`SCR_OFS_CTRL:      next_rdata = ctrl & `SCR_MASK_CTRL;
			`SCR_OFS_FLAGS_SET: next_rdata = flags & `SCR_MASK_FLAGS;
			`SCR_OFS_FLAGS_CLR: next_rdata = flags & `SCR_MASK_FLAGS;
			`SCR_OFS_MODE:      next_rdata = {6'h00, mode};
			`SCR_OFS_STATUS:    next_rdata = {6'h00, state};
			`SCR_OFS_DBGCTRL:   next_rdata = dbg & `SCR_MASK_DBG;
			default:            next_rdata = 8'h00; // Unmapped reads zero
		endcase
		// Data stands only in the cycle RVALID is high, zero otherwise
		if (!RD_EN) begin
			next_rdata = 8'h00;
		end
	end

	// Output stage next values; ports leave from flip-flops only, which costs
	// one cycle of latency on FLAGS, MODE and DBG_RUN but keeps them glitch free
	always_comb begin
		next_rvalid   = RD_EN;
		next_flags    = flags;
		next_mode_out = mode;
		next_dbg_run  = dbg[0];
	end

	// Register state; reserved bit 7 of control is never stored, so a
	// software reset is a single pulse and cannot stick
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl  <= `SCR_RST_CTRL;
			mode  <= `SCR_RST_MODE;
			dbg   <= `SCR_RST_DBG;
			state <= scr_pkg::SCR_ST_IDLE;
		end else begin
			ctrl  <= next_ctrl;
			mode  <= next_mode;
			dbg   <= next_dbg;
			state <= next_state;
		end
	end

	// Output registers; all clear at reset so nothing stands before a read
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA   <= 8'h00;
			RVALID  <= 1'b0;
			FLAGS   <= 8'h00;
			MODE    <= 2'h0;
			DBG_RUN <= 1'b0;
		end else begin
			RDATA   <= next_rdata;
			RVALID  <= next_rvalid;
			FLAGS   <= next_flags;
			MODE    <= next_mode_out;
			DBG_RUN <= next_dbg_run;
		end
	end
endmodule

`default_nettype wire

/* File: core/scr_setclr_bits.sv */
/*
 One shared set/clear value: writes of ones through the set or the clear
 address change single bits, clear wins. Assumes one-cycle write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"

module scr_setclr_bits #(
	parameter logic [7:0] MASK  = 8'hFF, // Implemented bits
	parameter logic [7:0] RST_V = 8'h00  // Reset value
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       sw_rst,  // Synchronous return to reset value
	input  wire logic       set_we,  // Write strobe, set address
	input  wire logic       clr_we,  // Write strobe, clear address
	input  wire logic [7:0] wdata,     // Set data
	input  wire logic [7:0] clr_wdata, // Clear data, may meet a set in one cycle
	input  wire logic [7:0] hw_set,  // Hardware events
	output logic      [7:0] value
);
	logic [7:0] next_value; // Next shared value

	// Next value: set first, then clear so that clear takes precedence
	always_comb begin
		next_value = value;
		if (set_we) begin
			next_value = next_value | wdata;
		end
		if (clr_we) begin
			next_value = next_value & ~clr_wdata;
		end
		// Hardware events are applied after set and clear so none is lost under a clear
		next_value = (next_value | hw_set) & MASK;
		if (sw_rst) begin
			next_value = RST_V & MASK;
		end
	end

	// Register stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			value <= RST_V & MASK;
		end else begin
			value <= next_value;
		end
	end
endmodule

`default_nettype wire

/* File: pkg/scr_cfg.svh */
/*
 Constants for the set/clear register bank: register offsets, field masks,
 reset values and widths. Assumes an 8-bit peripheral register bus.
*/
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// Data and address widths of the register port
`define SCR_DW            8
`define SCR_AW            4
// Register offsets
`define SCR_OFS_CTRL      4'h0
`define SCR_OFS_FLAGS_SET 4'h1
`define SCR_OFS_FLAGS_CLR 4'h2
`define SCR_OFS_MODE      4'h3
`define SCR_OFS_STATUS    4'h4
`define SCR_OFS_DBGCTRL   4'h5
// Writable bit masks; the other bits are reserved
`define SCR_MASK_CTRL     8'h0F
`define SCR_MASK_FLAGS    8'h7F
`define SCR_MASK_DBG      8'h01
// Mode field position and width
`define SCR_MODE_LSB      0
`define SCR_MODE_W        2
// Reset values
`define SCR_RST_CTRL      8'h00
`define SCR_RST_FLAGS     8'h00
`define SCR_RST_MODE      2'h0
`define SCR_RST_DBG       8'h00
// Software reset bit in the control register
`define SCR_CTRL_SWRST    7

`endif

/* File: pkg/scr_pkg.sv */
/*
 Types for the set/clear register bank.
 Assumes scr_cfg.svh supplies the numeric constants.
*/
package scr_pkg;
	// Mode encodings; 2'h3 is reserved and never stored
	typedef enum logic [1:0] {
		SCR_MODE_OFF  = 2'h0,
		SCR_MODE_ONE  = 2'h1,
		SCR_MODE_CONT = 2'h2
	} scr_mode_e;
	// Read-only state encoding reported to software
	typedef enum logic [1:0] {
		SCR_ST_IDLE = 2'h0,
		SCR_ST_RUN  = 2'h1,
		SCR_ST_DONE = 2'h3
	} scr_state_e;
endpackage

/* File: test/scr_regbank_asserts.sv */
/*
 Port checker for the register bank.
 Assumes it is bound into scr_regbank and clocked by CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"
module scr_regbank_asserts (
	input wire logic               CLK_SYS,
	input wire logic               ARST_N,
	input wire logic               WR_EN,
	input wire logic               RD_EN,
	input wire logic               WR_CLR_EN,
	input wire logic [`SCR_AW-1:0] ADDR,
	input wire logic [`SCR_DW-1:0] WDATA,
	input wire logic [`SCR_DW-1:0] CLR_WDATA,
	input wire logic [`SCR_DW-1:0] HW_EVENT,
	input wire logic [`SCR_DW-1:0] RDATA,
	input wire logic               RVALID,
	input wire logic [`SCR_DW-1:0] FLAGS
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	// Hardware events beat clear, so flag checks want them quiet
	wire logic quiet = HW_EVENT == 8'h00;
	wire logic pair = ADDR == `SCR_OFS_FLAGS_SET || ADDR == `SCR_OFS_FLAGS_CLR;
	property p_rd; RD_EN |=> RVALID; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_pair; RVALID && $past(pair) |-> RDATA == FLAGS; endproperty
	a_pair: assert property (p_pair) else $error("pair read differs");
	property p_resv; RVALID && $past(ADDR) == `SCR_OFS_CTRL |-> RDATA[7:4] == 4'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bits set");
	property p_stat; RVALID && $past(ADDR) == `SCR_OFS_STATUS |-> RDATA inside {8'h00, 8'h01, 8'h03};
	endproperty
	a_stat: assert property (p_stat) else $error("bad status code");
	property p_clr; WR_EN && ADDR == `SCR_OFS_FLAGS_CLR && !WR_CLR_EN && quiet
		|-> ##2 (FLAGS & $past(WDATA, 2)) == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("clear failed");
	property p_set; WR_EN && ADDR == `SCR_OFS_FLAGS_SET && !WR_CLR_EN
		|-> ##2 (FLAGS & $past(WDATA, 2)) == ($past(WDATA, 2) & `SCR_MASK_FLAGS); endproperty
	a_set: assert property (p_set) else $error("set failed");
	property p_both; WR_EN && WR_CLR_EN && ADDR == `SCR_OFS_FLAGS_SET && quiet
		|-> ##2 (FLAGS & $past(CLR_WDATA, 2)) == 8'h00; endproperty
	a_both: assert property (p_both) else $error("clear lost to set");
	property p_bset; WR_EN && WR_CLR_EN && ADDR == `SCR_OFS_FLAGS_SET
		|-> ##2 (FLAGS & $past(WDATA, 2) & ~$past(CLR_WDATA, 2))
		== ($past(WDATA, 2) & ~$past(CLR_WDATA, 2) & `SCR_MASK_FLAGS); endproperty
	a_bset: assert property (p_bset) else $error("set lost beside clear");
	property p_keep; WR_EN && pair && !WR_CLR_EN && quiet
		|-> ##2 ((FLAGS ^ $past(FLAGS)) & ~$past(WDATA, 2)) == 8'h00; endproperty
	a_keep: assert property (p_keep) else $error("zero bit changed");
	property p_swr; WR_EN && ADDR == `SCR_OFS_CTRL && WDATA[7] && quiet |-> ##2 FLAGS == 8'h00;
	endproperty
	a_swr: assert property (p_swr) else $error("soft reset kept flags");
endmodule
bind scr_regbank scr_regbank_asserts i_chk (.*);
`default_nettype wire

/* File: test/scr_regbank_tb.sv */
/*
 Directed bench for scr_regbank: register writes, reads and checks.
 Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scr_cfg.svh"
module scr_regbank_tb;
	logic       clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, clr_en = 1'b0, done = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, cdata = 8'h00, hw = 8'h00, rdata, flags;
	logic [1:0] mode;
	logic       rvalid, dbg;
	int         n_mismatch = 0, n_tests = 0;
	// 10 MHz system clock
	always #50 clk = ~clk;
	scr_regbank i_dut (.CLK_SYS(clk), .ARST_N(arst_n), .WR_EN(wr_en), .RD_EN(rd_en),
		.WR_CLR_EN(clr_en), .ADDR(addr), .WDATA(wdata), .CLR_WDATA(cdata), .HW_EVENT(hw),
		.RUN_DONE(done), .RDATA(rdata), .RVALID(rvalid), .FLAGS(flags), .MODE(mode),
		.DBG_RUN(dbg));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// One write; the strobe drops at the edge that takes it
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic c = 1'b0,
		input logic [7:0] cd = 8'h00);
		@(posedge clk);
		{wr_en, clr_en, addr, wdata, cdata} <= {1'b1, c, a, d, cd};
		@(posedge clk);
		{wr_en, clr_en} <= 2'h0;
	endtask
	// One read, judged in the cycle the answer stands
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		{rd_en, addr} <= {1'b1, a};
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(n, rdata, e);
		chk("rvalid", {7'h00, rvalid}, 8'h01);
	endtask
	task automatic t_pair;
		wr(`SCR_OFS_FLAGS_SET, 8'h25);
		rd(`SCR_OFS_FLAGS_CLR, 8'h25, "flags");
		rd(`SCR_OFS_FLAGS_SET, 8'h25, "flags");
		chk("flags port", flags, 8'h25);
		wr(`SCR_OFS_FLAGS_CLR, 8'h05);
		rd(`SCR_OFS_FLAGS_SET, 8'h20, "flags");
		// Lone clear strobe while hardware events hit bit 3 and reserved bit 7
		@(posedge clk);
		{clr_en, cdata, hw} <= {1'b1, 8'h20, 8'h88};
		@(posedge clk);
		{clr_en, hw} <= 9'h000;
		rd(`SCR_OFS_FLAGS_SET, 8'h08, "flags");
	endtask
	task automatic t_both;
		wr(`SCR_OFS_FLAGS_SET, 8'h0C);
		// Set 03 and clear 06 together: bit 1 cleared, bit 0 set, bit 2 cleared
		wr(`SCR_OFS_FLAGS_SET, 8'h03, 1'b1, 8'h06);
		rd(`SCR_OFS_FLAGS_CLR, 8'h09, "flags");
	endtask
	task automatic t_resv;
		wr(`SCR_OFS_CTRL, 8'h0F);
		rd(`SCR_OFS_CTRL, 8'h0F, "ctrl");
		wr(`SCR_OFS_DBGCTRL, 8'h01);
		rd(`SCR_OFS_DBGCTRL, 8'h01, "dbg");
		rd(4'hF, 8'h00, "unmapped");
		// Only defined mode encodings are ever sent
		wr(`SCR_OFS_MODE, 8'h02);
		rd(`SCR_OFS_MODE, 8'h02, "mode");
		chk("mode port", {6'h00, mode}, 8'h02);
	endtask
	task automatic t_stat;
		rd(`SCR_OFS_STATUS, 8'h01, "status");
		wr(`SCR_OFS_MODE, 8'h01);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		rd(`SCR_OFS_STATUS, 8'h03, "status");
	endtask
	task automatic t_swrst;
		wr(`SCR_OFS_FLAGS_SET, 8'h11);
		wr(`SCR_OFS_CTRL, 8'h80);
		rd(`SCR_OFS_CTRL, 8'h00, "ctrl");
		rd(`SCR_OFS_FLAGS_SET, 8'h00, "flags");
		rd(`SCR_OFS_MODE, 8'h00, "mode");
		rd(`SCR_OFS_STATUS, 8'h00, "status");
		rd(`SCR_OFS_DBGCTRL, 8'h01, "dbg");
		chk("dbg port", {7'h00, dbg}, 8'h01);
		chk("mode port", {6'h00, mode}, 8'h00);
		chk("flags port", flags, 8'h00);
	endtask
	task automatic stop_test;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_pair;
		t_both;
		t_resv;
		t_stat;
		t_swrst;
		stop_test;
	end
	// Whole run is about 60 cycles, some 6 us; this is ample
	initial begin
		#100us;
		n_mismatch++;
		stop_test;
	end
endmodule
`default_nettype wire
